//--- hw/fault_pkg.sv
// constants and carrier types for the led channel fault supervisor
package fault_pkg;
	localparam int CLK_MHZ      = 250;
	localparam int DEGLITCH_MS  = 2;
	localparam int DEGLITCH_CYC = DEGLITCH_MS * CLK_MHZ * 1000;
	localparam int DIM_CYCLES   = 7;
	localparam int TIMER_W      = 20;
	localparam int NCH          = 3;
	localparam int AW           = 12;

	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_CHAN   = 12'h008;
	localparam int          CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0001;

	// junction temperature in degrees celsius, then current in percent of full
	localparam logic [7:0] SHUT_ON   = 8'haa;
	localparam logic [7:0] SHUT_OFF  = 8'h9b;
	localparam logic [7:0] FOLD_ON   = 8'h6e;
	localparam logic [7:0] FOLD_OFF  = 8'h64;
	localparam logic [7:0] FOLD_SPAN = 8'h19;
	localparam logic [7:0] PCT_FULL  = 8'h64;
	localparam logic [7:0] PCT_KNEE  = 8'h32;

	typedef struct packed {
		logic [2:0] headroom_low;
		logic [2:0] output_low;
		logic [2:0] sense_low;
		logic       ref_bad;
	} comp_t;

	typedef struct packed {
		logic [8:0] rsv1;
		logic [6:0] pct;
		logic       rsv0;
		logic       bus_low;
		logic       ext_s;
		logic       ext_c;
		logic       fold;
		logic       hot;
		logic       ref_lat;
		logic [2:0] single_lat;
		logic [2:0] short_lat;
		logic [2:0] open_act;
	} status_t;
endpackage

//--- hw/deglitch.sv
// persistence filters for the per-channel comparator flags
`timescale 1ns/1ns
`default_nettype none
module deglitch #(
	parameter int N        = 9,
	parameter int TIME_CYC = fault_pkg::DEGLITCH_CYC,
	parameter int DIM_CNT  = fault_pkg::DIM_CYCLES
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [N-1:0] cond,
	input  wire logic [N-1:0] gate,
	input  wire logic [N-1:0] dim,
	output logic      [N-1:0] confirmed
);
	localparam int TW = fault_pkg::TIMER_W;
	localparam logic [TW-1:0] T_LAST = TW'(TIME_CYC - 1);
	localparam logic [3:0]    C_LAST = 4'(DIM_CNT - 1);

	typedef struct packed {
		logic [N-1:0][TW-1:0] timer;
		logic [N-1:0][3:0]    cyc;
		logic [N-1:0]         dim_prev;
		logic [N-1:0]         conf;
	} deg_state_t;

	deg_state_t st_q;
	deg_state_t st_d;

	always_comb
	begin
		st_d = st_q;
		for (int i = 0; i < N; i++)
		begin
			st_d.dim_prev[i] = dim[i];
			if (gate[i] && !cond[i])
			begin
				// any break in persistence starts over
				st_d.timer[i] = '0;
				st_d.cyc[i] = 4'h0;
				st_d.conf[i] = 1'b0;
			end
			else
			begin
				if (!gate[i])
				begin
					// the persistence timer does not run while the channel is off; dimming cycles still count
					st_d.timer[i] = '0;
					st_d.conf[i] = 1'b0;
				end
				else if (st_q.timer[i] == T_LAST)
					st_d.conf[i] = 1'b1;
				else
					st_d.timer[i] = st_q.timer[i] + 1'b1;
				if (st_q.dim_prev[i] && !dim[i])
				begin
					if (st_q.cyc[i] == C_LAST)
						st_d.conf[i] = 1'b1;
					else
						st_d.cyc[i] = st_q.cyc[i] + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign confirmed = st_q.conf;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_last_fall;
		st_q.dim_prev[0] && !dim[0] && st_q.cyc[0] == C_LAST && !(gate[0] && !cond[0]);
	endsequence

	a_dim_cycle_confirm: assert property (s_last_fall |=> confirmed[0])
		else $error("seventh dimming cycle did not confirm");
	a_time_confirm: assert property (gate[0] && cond[0] && st_q.timer[0] == T_LAST |=> confirmed[0])
		else $error("persistence time did not confirm");
endmodule
`default_nettype wire

//--- hw/led_fault_supervisor.sv
// fault supervision of a three channel led driver with apb status access
`timescale 1ns/1ns
`default_nettype none
module led_fault_supervisor #(
	parameter int DEGLITCH_CYC = fault_pkg::DEGLITCH_CYC
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic [fault_pkg::AW-1:0] paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    supply_above_5v,
	input  wire logic                    supply_above_9v,
	input  wire logic [2:0]              channel_dim_input,
	input  wire fault_pkg::comp_t        cmp,
	input  wire logic [7:0]              junction_temp,
	input  wire logic                    fault_in,
	output logic                         fault_out,
	output logic                         fault_oe_n,
	input  wire logic                    single_in,
	output logic                         single_out,
	output logic                         single_oe_n,
	output logic      [2:0]              chan_enable,
	output logic      [6:0]              current_pct
);
	localparam int NCH = fault_pkg::NCH;

	typedef struct packed {
		logic            ctrl_en;
		logic            c_oe_n;
		logic            s_oe_n;
		logic            od_out;
		logic [NCH-1:0]  short_lat;
		logic [NCH-1:0]  single_lat;
		logic            ref_lat;
		logic            hot;
		logic            fold;
		logic            ext_c;
		logic            ext_s;
		logic [NCH-1:0]  chan_en;
		logic [6:0]      pct;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
	} top_state_t;

	localparam top_state_t ST_RST = '{
		ctrl_en: fault_pkg::CTRL_RST[fault_pkg::CTRL_EN_BIT],
		c_oe_n:  1'b1,
		s_oe_n:  1'b1,
		default: '0
	};

	top_state_t         st_q;
	top_state_t         st_d;
	logic [3*NCH-1:0]   dg_cond;
	logic [3*NCH-1:0]   dg_gate;
	logic [3*NCH-1:0]   dg_conf;
	logic [NCH-1:0]     open_conf;
	logic [NCH-1:0]     short_conf;
	logic [NCH-1:0]     single_conf;
	logic [NCH-1:0]     short_mask;
	logic [NCH-1:0]     open_mask;
	logic               common_req;
	logic               single_req;
	logic               bus_low;
	logic               base_on;
	logic               access;
	fault_pkg::status_t status_w;

	function automatic logic reg_hit(input logic [fault_pkg::AW-1:0] a,
		input logic [fault_pkg::AW-1:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic [6:0] fold_pct(input logic [7:0] t);
		logic [7:0] dt;
		logic [7:0] p;
		dt = (t > fault_pkg::FOLD_ON) ? t - fault_pkg::FOLD_ON : 8'h00;
		if (dt <= fault_pkg::FOLD_SPAN)
			p = fault_pkg::PCT_FULL - {dt[6:0], 1'b0};
		else if (dt - fault_pkg::FOLD_SPAN >= fault_pkg::PCT_KNEE)
			p = 8'h00;
		else
			p = fault_pkg::PCT_KNEE - (dt - fault_pkg::FOLD_SPAN);
		return p[6:0];
	endfunction

	// headroom watch runs whether the channel is on or off
	assign dg_cond = {cmp.sense_low & {NCH{supply_above_9v}},
		cmp.output_low & {NCH{supply_above_5v}},
		cmp.headroom_low & {NCH{supply_above_5v}}};
	assign dg_gate = {channel_dim_input & st_q.chan_en,
		channel_dim_input & st_q.chan_en, {NCH{1'b1}}};

	deglitch #(
		.N        (3 * NCH),
		.TIME_CYC (DEGLITCH_CYC),
		.DIM_CNT  (fault_pkg::DIM_CYCLES)
	) deglitch_i (
		.pclk      (pclk),
		.presetn   (presetn),
		.cond      (dg_cond),
		.gate      (dg_gate),
		.dim       ({3{channel_dim_input}}),
		.confirmed (dg_conf)
	);

	assign open_conf   = dg_conf[NCH-1:0];
	assign short_conf  = dg_conf[2*NCH-1:NCH];
	assign single_conf = dg_conf[3*NCH-1:2*NCH];

	always_comb
	begin
		st_d = st_q;
		common_req = 1'b0;
		single_req = 1'b0;
		bus_low = 1'b0;
		base_on = 1'b0;
		short_mask = '1;
		open_mask = '1;
		access = 1'b0;
		status_w = '0;

		// latched faults: a new detection wins over a clear by disable
		st_d.short_lat = short_conf | (st_q.short_lat & {NCH{st_q.ctrl_en}});
		st_d.single_lat = single_conf | (st_q.single_lat & {NCH{st_q.ctrl_en}});
		st_d.ref_lat = (cmp.ref_bad & supply_above_5v) | (st_q.ref_lat & st_q.ctrl_en);

		if (junction_temp > fault_pkg::SHUT_ON)
			st_d.hot = 1'b1;
		else if (junction_temp < fault_pkg::SHUT_OFF)
			st_d.hot = 1'b0;
		if (junction_temp > fault_pkg::FOLD_ON)
			st_d.fold = 1'b1;
		else if (junction_temp < fault_pkg::FOLD_OFF)
			st_d.fold = 1'b0;
		st_d.pct = st_q.fold ? fold_pct(junction_temp) : fault_pkg::PCT_FULL[6:0];

		// open load is never latched, so it releases on its own
		common_req = (|open_conf) | (|st_q.short_lat) | st_q.ref_lat | st_q.hot;
		single_req = |st_q.single_lat;

		// line reading high while we pull it means someone holds it high
		st_d.ext_c = common_req & (st_q.ext_c | (!st_q.c_oe_n & fault_in));
		st_d.c_oe_n = !(common_req & !st_d.ext_c);
		st_d.ext_s = single_req & (st_q.ext_s | (!st_q.s_oe_n & single_in));
		st_d.s_oe_n = !(single_req & !st_d.ext_s);

		// another device on the shared line asks for shutdown
		bus_low = st_q.c_oe_n & !fault_in;
		base_on = st_q.ctrl_en & !st_q.hot & !st_q.ref_lat & !bus_low;

		if (|st_q.short_lat)
		begin
			if (st_q.ext_c)
				short_mask = ~st_q.short_lat;
			else
				short_mask = '0;
		end
		// held-high line leaves every open or battery-shorted channel on
		if ((|open_conf) && !st_q.ext_c)
			open_mask = open_conf;
		st_d.chan_en = {NCH{base_on}} & short_mask & open_mask;

		status_w.open_act = open_conf;
		status_w.short_lat = st_q.short_lat;
		status_w.single_lat = st_q.single_lat;
		status_w.ref_lat = st_q.ref_lat;
		status_w.hot = st_q.hot;
		status_w.fold = st_q.fold;
		status_w.ext_c = st_q.ext_c;
		status_w.ext_s = st_q.ext_s;
		status_w.bus_low = bus_low;
		status_w.pct = st_q.pct;

		// apb: one wait state, answer registered
		access = psel & penable & !st_q.pready;
		st_d.pready = access;
		st_d.pslverr = 1'b0;
		if (access)
		begin
			st_d.pslverr = !(reg_hit(paddr, fault_pkg::OFS_CTRL)
				| reg_hit(paddr, fault_pkg::OFS_STATUS)
				| reg_hit(paddr, fault_pkg::OFS_CHAN));
			st_d.prdata = 32'h0000_0000;
			if (!pwrite)
			begin
				if (reg_hit(paddr, fault_pkg::OFS_CTRL))
					st_d.prdata[fault_pkg::CTRL_EN_BIT] = st_q.ctrl_en;
				else if (reg_hit(paddr, fault_pkg::OFS_STATUS))
					st_d.prdata = status_w;
				else if (reg_hit(paddr, fault_pkg::OFS_CHAN))
					st_d.prdata[NCH-1:0] = st_q.chan_en;
			end
			else if (reg_hit(paddr, fault_pkg::OFS_CTRL))
			begin
				st_d.ctrl_en = pwdata[fault_pkg::CTRL_EN_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= ST_RST;
		else
			st_q <= st_d;
	end

	assign prdata      = st_q.prdata;
	assign pready      = st_q.pready;
	assign pslverr     = st_q.pslverr;
	assign fault_out   = st_q.od_out;
	assign fault_oe_n  = st_q.c_oe_n;
	assign single_out  = st_q.od_out;
	assign single_oe_n = st_q.s_oe_n;
	assign chan_enable = st_q.chan_en;
	assign current_pct = st_q.pct;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_overheat;
		junction_temp > fault_pkg::SHUT_ON;
	endsequence

	sequence s_ref_bad;
		cmp.ref_bad && supply_above_5v;
	endsequence

	sequence s_open_free;
		(|open_conf) && !st_q.ext_c && !(!st_q.c_oe_n && fault_in);
	endsequence

	a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb access not answered in one wait state");
	a_hot_all_off: assert property (s_overheat |=> ##1 chan_enable == '0)
		else $error("channels still on after overheat");
	a_hot_recover: assert property (st_q.hot && junction_temp < fault_pkg::SHUT_OFF |=> !st_q.hot)
		else $error("overheat did not recover below lower threshold");
	a_ref_all_off: assert property (s_ref_bad |=> st_q.ref_lat ##1 chan_enable == '0)
		else $error("reference fault did not disable channels");
	a_open_pulls_line: assert property (s_open_free |=> !fault_oe_n)
		else $error("open load did not pull common line");
	a_line_release: assert property (!common_req |=> fault_oe_n)
		else $error("common line held without a fault");
	a_single_line: assert property ((|st_q.single_lat) && !st_q.ext_s
		&& !(!st_q.s_oe_n && single_in) |=> !single_oe_n)
		else $error("single short did not pull its line");
	a_short_float_off: assert property ((|st_q.short_lat) && !st_q.ext_c |=> chan_enable == '0)
		else $error("output short with floating line left channels on");
	a_latch_hold: assert property (st_q.short_lat[0] && st_q.ctrl_en |=> st_q.short_lat[0])
		else $error("latched short cleared while enabled");
	a_fold_enter: assert property (junction_temp > fault_pkg::FOLD_ON |=> st_q.fold)
		else $error("foldback not entered");
	a_fold_knee: assert property (st_q.fold
		&& junction_temp == fault_pkg::FOLD_ON + fault_pkg::FOLD_SPAN
		|=> current_pct == fault_pkg::PCT_KNEE[6:0])
		else $error("foldback knee current wrong");
	a_bus_shutdown: assert property (st_q.c_oe_n && !fault_in |=> chan_enable == '0)
		else $error("shared line low did not shut outputs");
	a_deglitch_restart: assert property (channel_dim_input[0] && st_q.chan_en[0]
		&& !(cmp.output_low[0] && supply_above_5v) |=> !short_conf[0])
		else $error("short deglitch not restarted");

	a_apb_pulse: assert property (pready |=> !pready)
		else $error("apb ready stood longer than one cycle");

	a_apb_err_ready: assert property (pslverr |-> pready)
		else $error("apb error without ready");

	a_open_keeps_own: assert property ((|open_conf) && !st_q.ext_c
		&& !(!st_q.c_oe_n && fault_in) && base_on && !(|st_q.short_lat)
		|=> chan_enable == $past(open_conf))
		else $error("open load did not keep only the open channel on");

	a_held_open_on: assert property ((|open_conf) && st_q.ext_c && base_on
		&& !(|st_q.short_lat) |=> chan_enable == 3'h7)
		else $error("open load with held line turned a channel off");

	a_short_line: assert property ((|st_q.short_lat) && !st_q.ext_c
		&& !(!st_q.c_oe_n && fault_in) |=> !fault_oe_n)
		else $error("output short did not pull common line");

	a_short_held_mask: assert property ((|st_q.short_lat) && st_q.ext_c
		|=> (chan_enable & $past(st_q.short_lat)) == 3'h0)
		else $error("shorted channel left on with held line");

	a_single_stays_on: assert property ((|st_q.single_lat) && base_on
		&& !(|st_q.short_lat) && !(|open_conf) |=> chan_enable == 3'h7)
		else $error("single short turned a channel off");

	a_hot_line: assert property (st_q.hot && !st_q.ext_c
		&& !(!st_q.c_oe_n && fault_in) |=> !fault_oe_n)
		else $error("overheat did not pull common line");

	a_fold_silent: assert property (st_q.fold && !st_q.hot && !(|open_conf)
		&& !(|st_q.short_lat) && !st_q.ref_lat |=> fault_oe_n)
		else $error("foldback pulled the common line");

	a_fold_exit: assert property (junction_temp < fault_pkg::FOLD_OFF |=> !st_q.fold)
		else $error("foldback not left below lower threshold");

	a_full_current: assert property (!st_q.fold |=> current_pct == fault_pkg::PCT_FULL[6:0])
		else $error("current not full outside foldback");

	a_fold_slope: assert property (st_q.fold
		&& junction_temp == fault_pkg::FOLD_ON + 8'h01 |=> current_pct == 7'h62)
		else $error("foldback slope wrong one degree above threshold");

	a_ref_line: assert property (st_q.ref_lat && !st_q.ext_c
		&& !(!st_q.c_oe_n && fault_in) |=> !fault_oe_n)
		else $error("reference fault did not pull common line");

	a_ref_hold: assert property (st_q.ref_lat && st_q.ctrl_en |=> st_q.ref_lat)
		else $error("reference latch cleared while enabled");

	a_single_release: assert property (st_q.ext_s |=> single_oe_n)
		else $error("single line still pulled while held high");

	a_ext_release: assert property (st_q.ext_c |=> fault_oe_n)
		else $error("common line still pulled while held high");

	a_enable_clear: assert property (!st_q.ctrl_en && !(|short_conf)
		|=> st_q.short_lat == 3'h0)
		else $error("short latch survived disable");
endmodule
`default_nettype wire

//--- testbench/fault_bus_model.sv
// open-drain fault lines with pull-ups, outside drivers and other devices
`timescale 1ns/1ns
`default_nettype none
module fault_bus_model (
	input  wire logic fault_oe_n,
	input  wire logic single_oe_n,
	input  wire logic hold_high_c,
	input  wire logic hold_high_s,
	input  wire logic other_pull,
	input  wire logic tie_lines,
	output logic      fault_line,
	output logic      single_line
);
	logic low_c;
	logic low_s;
	always_comb
	begin
		low_c = !fault_oe_n || other_pull || (tie_lines && !single_oe_n);
		low_s = !single_oe_n || (tie_lines && low_c);
		// a strong outside driver wins over any pulldown
		fault_line = hold_high_c || !low_c;
		single_line = hold_high_s || !low_s;
	end
endmodule
`default_nettype wire

//--- testbench/led_fault_supervisor_tb.sv
// self-checking bench for the led channel fault supervisor
`timescale 1ns/1ns
`default_nettype none
module led_fault_supervisor_tb;
	logic             pclk;
	logic             presetn;
	logic [11:0]      paddr;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             s5;
	logic             s9;
	logic [2:0]       dim;
	fault_pkg::comp_t cmp;
	logic [7:0]       temp;
	logic             fault_in;
	logic             fault_oe_n;
	logic             single_in;
	logic             single_oe_n;
	logic [2:0]       chan_enable;
	logic [6:0]       current_pct;
	logic             hold_c;
	logic             hold_s;
	logic             fault_out;
	logic             single_out;
	logic             other;
	logic             tie;
	logic [31:0]      rdat;
	logic             rerr;
	int               failures;
	int               tests_run;

	led_fault_supervisor #(.DEGLITCH_CYC(20)) led_fault_supervisor_i (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_above_5v(s5), .supply_above_9v(s9), .channel_dim_input(dim), .cmp(cmp),
		.junction_temp(temp), .fault_in(fault_in), .fault_out(fault_out),
		.fault_oe_n(fault_oe_n), .single_in(single_in), .single_out(single_out),
		.single_oe_n(single_oe_n),
		.chan_enable(chan_enable), .current_pct(current_pct));
	fault_bus_model fault_bus_model_i (.fault_oe_n(fault_oe_n), .single_oe_n(single_oe_n),
		.hold_high_c(hold_c), .hold_high_s(hold_s), .other_pull(other), .tie_lines(tie),
		.fault_line(fault_in), .single_line(single_in));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic report_and_stop();
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
		begin
			failures++;
			report_and_stop();
		end
		else
		begin
			rdat = prdata;
			rerr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask

	task automatic clear_latches();
		apb(1'b1, fault_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, fault_pkg::OFS_CTRL, 32'h1);
		cyc(4);
	endtask

	task automatic t_regs();
		apb(1'b0, fault_pkg::OFS_CTRL, 32'h0);
		chk(rdat, fault_pkg::CTRL_RST);
		apb(1'b1, fault_pkg::OFS_CHAN, 32'h0);
		apb(1'b0, fault_pkg::OFS_CHAN, 32'h0);
		chk(rdat, 32'h7);
		apb(1'b0, 12'h00c, 32'h0);
		chk(32'(rerr), 32'h1);
		chk(rdat, 32'h0);
	endtask

	task automatic t_open();
		cmp.headroom_low <= 3'h2;
		cyc(15);
		cmp.headroom_low <= 3'h0;
		cyc(1);
		cmp.headroom_low <= 3'h2;
		cyc(15);
		chk(32'(fault_oe_n), 32'h1);
		cyc(10);
		chk(32'(fault_oe_n), 32'h0);
		chk(32'(chan_enable), 32'h2);
		chk(32'({fault_out, single_out}), 32'h0);
		apb(1'b0, fault_pkg::OFS_STATUS, 32'h0);
		chk(rdat & 32'h7, 32'h2);
		cmp.headroom_low <= 3'h0;
		cyc(6);
		chk(32'(fault_oe_n), 32'h1);
		chk(32'(chan_enable), 32'h7);
	endtask

	task automatic t_battery();
		dim <= 3'h6;
		cmp.headroom_low <= 3'h1;
		cyc(25);
		chk(32'(fault_oe_n), 32'h0);
		chk(32'(chan_enable), 32'h1);
		cmp.headroom_low <= 3'h0;
		dim <= 3'h7;
		cyc(6);
		chk(32'(chan_enable), 32'h7);
	endtask

	task automatic t_open_held();
		hold_c <= 1'b1;
		cmp.headroom_low <= 3'h4;
		cyc(25);
		chk(32'(chan_enable), 32'h7);
		apb(1'b0, fault_pkg::OFS_STATUS, 32'h0);
		chk(32'(rdat[12]), 32'h1);
		cmp.headroom_low <= 3'h0;
		hold_c <= 1'b0;
		cyc(6);
	endtask

	task automatic t_short();
		s5 <= 1'b0;
		cmp.output_low <= 3'h4;
		cyc(25);
		chk(32'(fault_oe_n), 32'h1);
		s5 <= 1'b1;
		cyc(25);
		chk(32'(fault_oe_n), 32'h0);
		chk(32'(chan_enable), 32'h0);
		cmp.output_low <= 3'h0;
		cyc(10);
		chk(32'(fault_oe_n), 32'h0);
		clear_latches();
		chk(32'(fault_oe_n), 32'h1);
		chk(32'(chan_enable), 32'h7);
		hold_c <= 1'b1;
		cmp.output_low <= 3'h1;
		cyc(25);
		chk(32'(chan_enable), 32'h6);
		cmp.output_low <= 3'h0;
		hold_c <= 1'b0;
		clear_latches();
	endtask

	task automatic t_single();
		s9 <= 1'b0;
		cmp.sense_low <= 3'h1;
		cyc(25);
		chk(32'(single_oe_n), 32'h1);
		s9 <= 1'b1;
		cyc(25);
		chk(32'(single_oe_n), 32'h0);
		chk(32'(chan_enable), 32'h7);
		tie <= 1'b1;
		cyc(4);
		chk(32'(chan_enable), 32'h0);
		tie <= 1'b0;
		cmp.sense_low <= 3'h0;
		cyc(6);
		chk(32'(single_oe_n), 32'h0);
		hold_s <= 1'b1;
		cyc(3);
		chk(32'(single_oe_n), 32'h1);
		apb(1'b0, fault_pkg::OFS_STATUS, 32'h0);
		chk(32'(rdat[13]), 32'h1);
		hold_s <= 1'b0;
		clear_latches();
		chk(32'(single_oe_n), 32'h1);
	endtask

	task automatic t_heat();
		temp <= 8'hab;
		cyc(4);
		chk(32'(chan_enable), 32'h0);
		chk(32'(fault_oe_n), 32'h0);
		temp <= 8'ha0;
		cyc(4);
		chk(32'(chan_enable), 32'h0);
		temp <= 8'h9a;
		cyc(4);
		chk(32'(chan_enable), 32'h7);
		temp <= 8'h78;
		cyc(4);
		chk(32'(current_pct), 32'h50);
		chk(32'(fault_oe_n), 32'h1);
		temp <= 8'h87;
		cyc(4);
		chk(32'(current_pct), 32'h32);
		temp <= 8'h63;
		cyc(4);
		chk(32'(current_pct), 32'h64);
	endtask

	task automatic t_ref_other();
		cmp.ref_bad <= 1'b1;
		cyc(4);
		chk(32'(chan_enable), 32'h0);
		cmp.ref_bad <= 1'b0;
		cyc(4);
		chk(32'(fault_oe_n), 32'h0);
		clear_latches();
		other <= 1'b1;
		cyc(4);
		chk(32'(chan_enable), 32'h0);
		other <= 1'b0;
		cyc(4);
		chk(32'(chan_enable), 32'h7);
	endtask

	task automatic t_dim();
		cmp.headroom_low <= 3'h2;
		repeat (6)
		begin
			dim[1] <= 1'b1;
			cyc(1);
			dim[1] <= 1'b0;
			cyc(1);
		end
		chk(32'(fault_oe_n), 32'h1);
		dim[1] <= 1'b1;
		cyc(1);
		dim[1] <= 1'b0;
		cyc(3);
		chk(32'(fault_oe_n), 32'h0);
		cmp.headroom_low <= 3'h0;
		dim <= 3'h7;
		cyc(6);
	endtask

	initial
	begin
		failures = 0;
		tests_run = 0;
		presetn = 1'b0;
		{paddr, psel, penable, pwrite, pwdata} = '0;
		{s5, s9, dim, temp} = {1'b1, 1'b1, 3'h7, 8'h19};
		cmp = '0;
		{hold_c, hold_s, other, tie} = 4'h0;
		cyc(12);
		presetn <= 1'b1;
		cyc(3);
		chk(32'(chan_enable), 32'h7);
		chk(32'({fault_out, single_out}), 32'h0);
		t_regs();
		t_open();
		t_battery();
		t_open_held();
		t_short();
		t_single();
		t_heat();
		t_ref_other();
		t_dim();
		report_and_stop();
	end

	initial
	begin
		cyc(20000);
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
